// ---- rtl/iwd_consts.svh ----
/*
 Constants for the ISA memory window decoder: address windows, strap fields,
 clock limits and the power save encodings.
 Assumes inclusion by bare name from the design files.
*/
`ifndef IWD_CONSTS_SVH
`define IWD_CONSTS_SVH

// ----------------------------------------------------------------
// Address windows
// ----------------------------------------------------------------
`define IWD_SEL_LO 24'h0d0000
`define IWD_SEL_HI 24'h0dffff
`define IWD_M16_LO 24'h0c0000
`define IWD_M16_HI 24'h0dffff
`define IWD_BUF_BYTES 24'h00a000
`define IWD_REG_LO 24'h0dffe0
`define IWD_REG_HI 24'h0dffff

// ----------------------------------------------------------------
// Clock limits in MHz
// ----------------------------------------------------------------
`define IWD_CLK_MAX_DIV_MHZ 50
`define IWD_CLK_MAX_NODIV_MHZ 25

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define IWD_SYNC_FILL 2'h2

// ----------------------------------------------------------------
// APB map and fields
// ----------------------------------------------------------------
`define IWD_ADDR_CTRL 12'h000
`define IWD_ADDR_STAT 12'h004
`define IWD_CTRL_HWPS_EN 0
`define IWD_CTRL_SWPS 1
`define IWD_CTRL_RESET 32'h00000000
`define IWD_STAT_CFG_LSB 0
`define IWD_STAT_POL 5
`define IWD_STAT_DIV 6
`define IWD_STAT_PS 7
`define IWD_STAT_HWPS 8

`endif

// ---- rtl/iwd_pkg.sv ----
/*
 Types for the ISA memory window decoder.
 Assumes iwd_consts.svh is compiled alongside.
*/
package iwd_pkg;
   typedef enum logic [1:0] {
      IWD_HOST_ISA = 2'b00,
      IWD_HOST_OTHER = 2'b01
   } iwd_host_e;
   typedef logic [23:0] iwd_addr_t;
endpackage

// ---- rtl/iwd_sync.sv ----
/*
 Two flip-flop synchroniser for a bus of asynchronous levels.
 Assumes one clock and an asynchronous active low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module iwd_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Data
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
   assign sync_out = sync_q;
endmodule
`default_nettype wire

// ---- rtl/iwd_decoder.sv ----
/*
 ISA memory window decoder with strap capture, power save control and an
 APB register slave.
 Assumes ISA address, refresh, reset and straps arrive asynchronously;
 the select and 16-bit indication are combinational on the ISA pins.
*/
`timescale 1ns/10ps
`default_nettype none
`include "iwd_consts.svh"
module iwd_decoder
   import iwd_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // ISA bus
   input wire logic [23:0] isa_addr,
   input wire logic isa_refresh_n,
   input wire logic isa_reset,
   output logic ctl_cs_n,
   output logic memcs16_n,
   output logic ctl_reset_n,
   output logic buf_hit,
   output logic reg_hit,
   // Straps and controls
   input wire logic [3:0] bus_config_straps,
   input wire logic bus_start_n,
   input wire logic power_polarity_strap,
   input wire logic clk_div_strap,
   input wire logic hw_power_save_in,
   input wire logic panel_on,
   output logic panel_power_enable,
   output logic power_save,
   output logic [1:0] host_type
);
   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic in_win;
   assign in_win = (isa_addr >= `IWD_SEL_LO) && (isa_addr <= `IWD_SEL_HI);
   // only the ISA strap setting lets this decoder drive the select.
   assign ctl_cs_n = !(in_win && isa_refresh_n && !isa_reset
                       && host_type == IWD_HOST_ISA);
   assign memcs16_n = !((isa_addr >= `IWD_M16_LO) && (isa_addr <= `IWD_M16_HI));
   // Selected addresses between the buffer end and the register set hit
   // neither; the controller ignores accesses there.
   assign buf_hit = !ctl_cs_n
                    && (isa_addr < (`IWD_SEL_LO + `IWD_BUF_BYTES));
   assign reg_hit = !ctl_cs_n && (isa_addr >= `IWD_REG_LO);
   assign ctl_reset_n = !isa_reset;

   // ----------------------------------------------------------------
   // Synchronised inputs
   // ----------------------------------------------------------------
   logic [8:0] raw_s;
   logic [8:0] syn_s;
   assign raw_s = {isa_reset, bus_config_straps, bus_start_n,
                   power_polarity_strap, clk_div_strap, hw_power_save_in};
   iwd_sync #(.W(9)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(raw_s),
      .sync_out(syn_s)
   );
   logic rst_s;
   logic [4:0] cfg_s;
   logic pol_s;
   logic div_s;
   logic hwps_s;
   assign rst_s = syn_s[8];
   assign cfg_s = syn_s[7:3];
   assign pol_s = syn_s[2];
   assign div_s = syn_s[1];
   assign hwps_s = syn_s[0];

   // ----------------------------------------------------------------
   // Synchroniser fill tracking
   // ----------------------------------------------------------------
   logic [1:0] fill_q, fill_d;
   logic sync_full;
   assign sync_full = (fill_q == `IWD_SYNC_FILL);
   always_comb begin
      fill_d = fill_q;
      if (!sync_full) begin
         fill_d = fill_q + 2'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fill_q <= 2'h0;
      end else begin
         fill_q <= fill_d;
      end
   end

   // ----------------------------------------------------------------
   // Strap capture at reset release
   // ----------------------------------------------------------------
   // The synchroniser leaves reset holding zeros rather than the pins, so
   // a release is only recognised once both stages carry real pin values.
   // The divider strap is captured and reported only; keeping the input
   // clock inside the limit it implies is left to the board.
   logic rst_prev_q, rst_prev_d;
   logic pol_q, pol_d;
   logic div_q, div_d;
   logic [4:0] cfg_q, cfg_d;
   logic release_evt;
   assign release_evt = sync_full && rst_prev_q && !rst_s;
   always_comb begin
      rst_prev_d = sync_full ? rst_s : 1'b1;
      pol_d = pol_q;
      div_d = div_q;
      cfg_d = cfg_q;
      if (release_evt) begin
         pol_d = pol_s;
         div_d = div_s;
         cfg_d = cfg_s;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_prev_q <= 1'b1;
         pol_q <= 1'b0;
         div_q <= 1'b0;
         cfg_q <= 5'h00;
      end else begin
         rst_prev_q <= rst_prev_d;
         pol_q <= pol_d;
         div_q <= div_d;
         cfg_q <= cfg_d;
      end
   end
   // Straps all low with bus start low select the ISA host interface.
   assign host_type = (cfg_q == 5'h00) ? IWD_HOST_ISA : IWD_HOST_OTHER;

   // ----------------------------------------------------------------
   // Control register and power save
   // ----------------------------------------------------------------
   logic [1:0] ctrl_q, ctrl_d;
   logic wr_acc;
   assign wr_acc = psel && penable && pwrite && (paddr == `IWD_ADDR_CTRL);
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_acc) begin
         ctrl_d = pwdata[1:0];
      end
   end
   logic hwps_act;
   assign hwps_act = ctrl_q[`IWD_CTRL_HWPS_EN] && hwps_s;
   logic ps_q, ps_d;
   logic pwr_q, pwr_d;
   always_comb begin
      ps_d = hwps_act || ctrl_q[`IWD_CTRL_SWPS];
      // Active level of the panel enable follows the captured strap.
      pwr_d = (panel_on && !ps_d && !rst_s) ? pol_q : !pol_q;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 2'b00;
         ps_q <= 1'b0;
         pwr_q <= 1'b1;
      end else begin
         ctrl_q <= ctrl_d;
         ps_q <= ps_d;
         pwr_q <= pwr_d;
      end
   end
   assign power_save = ps_q;
   assign panel_power_enable = pwr_q;

   // ----------------------------------------------------------------
   // APB read path
   // ----------------------------------------------------------------
   // Read data are loaded in the setup cycle, so prdata comes from a
   // flip-flop and stands through the whole access phase.
   logic [31:0] rd_q, rd_d;
   logic hit;
   assign hit = (paddr == `IWD_ADDR_CTRL) || (paddr == `IWD_ADDR_STAT);
   always_comb begin
      rd_d = rd_q;
      if (psel && !penable && !pwrite) begin
         rd_d = 32'h00000000;
         if (paddr == `IWD_ADDR_CTRL) begin
            rd_d[1:0] = ctrl_q;
         end else if (paddr == `IWD_ADDR_STAT) begin
            rd_d[`IWD_STAT_CFG_LSB +: 5] = cfg_q;
            rd_d[`IWD_STAT_POL] = pol_q;
            rd_d[`IWD_STAT_DIV] = div_q;
            rd_d[`IWD_STAT_PS] = ps_q;
            rd_d[`IWD_STAT_HWPS] = hwps_act;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_q <= 32'h00000000;
      end else begin
         rd_q <= rd_d;
      end
   end
   assign prdata = rd_q;
   assign pready = 1'b1;
   // Writes to the status word are dropped quietly; only offsets outside
   // the map answer with an error.
   assign pslverr = psel && penable && !hit;
endmodule
`default_nettype wire

// ---- test/iwd_decoder_assertions.sv ----
/*
 Checker for the ISA window decoder.
 Assumes it is bound to iwd_decoder and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module iwd_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire logic power_save,
   // ISA side
   input wire logic [23:0] isa_addr,
   input wire logic isa_refresh_n,
   input wire logic isa_reset,
   input wire logic ctl_cs_n,
   input wire logic memcs16_n,
   input wire logic ctl_reset_n,
   input wire logic buf_hit,
   input wire logic reg_hit,
   // Straps and controls
   input wire logic [3:0] bus_config_straps,
   input wire logic bus_start_n,
   input wire logic hw_power_save_in,
   input wire logic [1:0] host_type
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_sel;
      ctl_cs_n == !(isa_addr inside {[24'h0d0000:24'h0dffff]} && isa_refresh_n
         && !isa_reset && host_type == 2'b00);
   endproperty
   a_sel: assert property (p_sel) else $error("select wrong");
   property p_m16;
      memcs16_n == !(isa_addr inside {[24'h0c0000:24'h0dffff]});
   endproperty
   a_m16: assert property (p_m16) else $error("wide wrong");
   property p_buf;
      buf_hit == (!ctl_cs_n && isa_addr < 24'h0da000);
   endproperty
   a_buf: assert property (p_buf) else $error("buffer hit wrong");
   property p_reg;
      reg_hit == (!ctl_cs_n && isa_addr >= 24'h0dffe0);
   endproperty
   a_reg: assert property (p_reg) else $error("register hit wrong");
   property p_rst;
      ctl_reset_n == !isa_reset;
   endproperty
   a_rst: assert property (p_rst) else $error("reset wrong");
   property p_sw;
      psel && penable && pwrite && paddr == 12'h000 && !pwdata[0]
         |-> ##2 power_save == $past(pwdata[1], 2);
   endproperty
   a_sw: assert property (p_sw) else $error("soft save wrong");
   property p_hw;
      psel && penable && pwrite && paddr == 12'h000 && pwdata[1:0] == 2'b01
         ##1 (hw_power_save_in && !psel)[*4] |-> power_save;
   endproperty
   a_hw: assert property (p_hw) else $error("hard save wrong");
   property p_cfg;
      $fell(isa_reset) ##1 ($stable({bus_config_straps, bus_start_n}) && !isa_reset)[*5]
         |-> host_type == ({bus_config_straps, bus_start_n} == 5'h00 ? 2'b00 : 2'b01);
   endproperty
   a_cfg: assert property (p_cfg) else $error("host type wrong");
   c_reg: cover property (!ctl_cs_n && reg_hit);
   c_m16: cover property (!memcs16_n && ctl_cs_n);
   c_err: cover property (pslverr);
endmodule
bind iwd_decoder iwd_chk chk_u (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pslverr(pslverr),
   .power_save(power_save),
   .isa_addr(isa_addr),
   .isa_refresh_n(isa_refresh_n),
   .isa_reset(isa_reset),
   .ctl_cs_n(ctl_cs_n),
   .memcs16_n(memcs16_n),
   .ctl_reset_n(ctl_reset_n),
   .buf_hit(buf_hit),
   .reg_hit(reg_hit),
   .bus_config_straps(bus_config_straps),
   .bus_start_n(bus_start_n),
   .hw_power_save_in(hw_power_save_in),
   .host_type(host_type)
);
`default_nettype wire

// ---- test/iwd_isa_host.sv ----
/*
 ISA host memory cycle model.
 Assumes requests are given by the bench at rising edges.
*/
`timescale 1ns/10ps
`default_nettype none
module iwd_isa_host (
   input wire logic pclk,
   input wire logic cyc,
   input wire logic [23:0] a,
   input wire logic rf,
   output logic [23:0] isa_addr = 24'h000000,
   output logic isa_refresh_n = 1'b1
);
   // Between cycles the address is not held, so it toggles.
   always_ff @(posedge pclk) begin
      isa_addr <= cyc ? a : ~isa_addr;
      isa_refresh_n <= cyc ? rf : 1'b1;
   end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
/*
 Self-checking bench for the ISA window decoder.
 Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cyc = 0, rf = 1, e;
   logic isa_reset = 0, bus_start_n = 0, power_polarity_strap = 0, clk_div_strap = 0;
   logic hw_power_save_in = 0, panel_on = 0, ish = 1;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic [23:0] a = 0, isa_addr;
   logic [3:0] bus_config_straps = 0;
   wire [31:0] prdata;
   wire [1:0] host_type;
   wire pready, pslverr, ctl_cs_n, memcs16_n, ctl_reset_n, buf_hit, reg_hit;
   wire panel_power_enable, power_save, isa_refresh_n;
   int err_count = 0, cmp_count = 0;
   logic [23:0] bq[$] = '{24'h0bffff, 24'h0c0000, 24'h0cffff, 24'h0d0000, 24'h0d9fff,
      24'h0da000, 24'h0dffdf, 24'h0dffe0, 24'h0dffff, 24'h0e0000};
   iwd_isa_host host_u (.pclk, .cyc, .a, .rf, .isa_addr, .isa_refresh_n);
   iwd_decoder dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .isa_addr, .isa_refresh_n, .isa_reset, .ctl_cs_n, .memcs16_n,
      .ctl_reset_n, .buf_hit, .reg_hit, .bus_config_straps, .bus_start_n,
      .power_polarity_strap, .clk_div_strap, .hw_power_save_in, .panel_on,
      .panel_power_enable, .power_save, .host_type);
   initial forever #5 pclk = ~pclk;
   task chk(input string n, input logic [31:0] s, input logic [31:0] x);
      cmp_count++;
      if (s !== x) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, x, s);
      end
   endtask
   task report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      chk("pready", pready, 1);
      rd = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task isa(input logic [23:0] x, input logic r);
      logic s;
      @(posedge pclk);
      {cyc, a, rf} <= {1'b1, x, r};
      @(posedge pclk);
      @(negedge pclk);
      s = x >= 24'h0d0000 && x <= 24'h0dffff && r && !isa_reset && ish;
      chk("decode", {!ctl_cs_n, buf_hit, reg_hit, !memcs16_n}, {s, s && x < 24'h0da000,
         s && x >= 24'h0dffe0, x >= 24'h0c0000 && x <= 24'h0dffff});
      chk("ctl_reset_n", ctl_reset_n, !isa_reset);
      @(posedge pclk);
   endtask
   initial begin
      #100000;
      err_count++;
      report_and_stop;
   end
   initial begin
      void'($urandom(32'h112f3693));
      repeat (3) @(posedge pclk);
      presetn <= 1;
      repeat (4) @(posedge pclk);
      foreach (bq[i]) begin
         isa(bq[i], 1);
         isa(bq[i], 0);
      end
      repeat (40) isa(24'h0b0000 + 24'($urandom % 32'h40000), 1'($urandom));
      isa_reset <= 1;
      isa(24'h0d0000, 1);
      isa_reset <= 0;
      hw_power_save_in <= 1;
      panel_on <= 1;
      repeat (5) @(posedge pclk);
      chk("ps_off", {power_save, panel_power_enable}, 2'b00);
      apb(1, 12'h000, 1);
      repeat (4) @(posedge pclk);
      apb(0, 12'h004, 0);
      chk("stat_hw", rd[8:7], 2'b11);
      apb(1, 12'h000, 2);
      hw_power_save_in <= 0;
      apb(0, 12'h000, 0);
      chk("ctrl", rd, 2);
      chk("ps_sw", {power_save, panel_power_enable}, 2'b11);
      apb(0, 12'h008, 0);
      chk("unmapped_err", e, 1'b1);
      chk("unmapped_rd", rd, 32'h0);
      apb(1, 12'h000, 0);
      bus_config_straps <= 4'h5;
      {power_polarity_strap, clk_div_strap, isa_reset} <= 3'b111;
      repeat (4) @(posedge pclk);
      isa_reset <= 0;
      ish = 0;
      repeat (6) @(posedge pclk);
      chk("host", host_type, 1);
      apb(0, 12'h004, 0);
      chk("stat", rd[6:0], 7'h6a);
      chk("ppe", panel_power_enable, 1);
      isa(24'h0dfff0, 1);
      report_and_stop;
   end
endmodule
`default_nettype wire
